// [verilog/tvr_pkg.sv]
package tvr_pkg;

	// Register offsets within the module's 64 KB window.
	localparam logic [15:0] OFF_STATUS    = 16'h1002;
	localparam logic [15:0] OFF_RELOC_HI  = 16'h1004;
	localparam logic [15:0] OFF_RELOC_LO  = 16'h1006;
	localparam logic [15:0] OFF_RELOC_SEL = 16'h1008;
	localparam logic [15:0] OFF_IRQ_LEVEL = 16'h100A;
	localparam logic [15:0] OFF_IRQ_VEC   = 16'h100C;
	localparam logic [15:0] OFF_SLOT      = 16'h100E;
	localparam logic [15:0] OFF_MCST      = 16'h1010;
	localparam logic [15:0] OFF_CHAIN     = 16'h1012;
	localparam logic [15:0] OFF_MRESET    = 16'h1014;
	localparam logic [15:0] OFF_SCLEAR    = 16'h1016;
	localparam logic [15:0] OFF_EVRESET   = 16'h1018;
	localparam logic [15:0] OFF_STRIG     = 16'h101A;
	localparam logic [15:0] OFF_EVCNT     = 16'h101C;
	localparam logic [15:0] OFF_EVSTORED  = 16'h1020;
	localparam logic [15:0] OFF_FILL      = 16'h1022;
	localparam logic [15:0] OFF_BLKEV     = 16'h1024;
	localparam logic [15:0] OFF_FWREV     = 16'h1026;
	localparam logic [15:0] OFF_LOOP      = 16'h1028;

	// Values after reset.
	localparam logic [7:0]  RST_RELOC     = 8'h00;
	localparam logic [2:0]  RST_IRQ_LEVEL = 3'h0;
	localparam logic [7:0]  RST_IRQ_VEC   = 8'hDD;
	localparam logic [4:0]  RST_SLOT      = 5'h1F;
	localparam logic [7:0]  RST_MCST      = 8'hAA;
	localparam logic [7:0]  RST_CHAIN     = 8'h00;
	localparam logic [15:0] RST_FILL      = 16'h0040;
	localparam logic [7:0]  RST_BLKEV     = 8'h00;
	// Firmware revision code; the value is arbitrary.
	localparam logic [7:0]  FW_REVISION   = 8'h10;

	// Output buffer sizing: full at capacity less a margin.
	localparam int unsigned OBUF_CAPACITY = 32768;
	localparam int unsigned FULL_MARGIN   = 33;
	localparam logic [15:0] FULL_LEVEL    =
		16'(OBUF_CAPACITY - FULL_MARGIN);

	// Resolution codes.
	localparam logic [1:0] RES_800PS = 2'b00;
	localparam logic [1:0] RES_200PS = 2'b01;
	localparam logic [1:0] RES_100PS = 2'b10;
	localparam logic [1:0] RES_25PS  = 2'b11;

	// Status word bit positions.
	localparam int ST_HAS_DATA = 0;
	localparam int ST_AFULL    = 1;
	localparam int ST_FULL     = 2;
	localparam int ST_TRIGWIN  = 3;
	localparam int ST_HEADER   = 4;
	localparam int ST_TERM     = 5;
	localparam int ST_ERR0     = 6;
	localparam int ST_BERR     = 10;
	localparam int ST_PURGED   = 11;
	localparam int ST_RES0     = 12;
	localparam int ST_PAIR     = 14;
	localparam int ST_TRGLOST  = 15;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic        wide;
		logic [31:0] addr;
		logic [31:0] wdata;
	} tvr_bus_req_t;

	typedef struct packed {
		logic [15:0] words;
		logic [15:0] events;
		logic        trig_window;
		logic        header_en;
		logic        pair_mode;
		logic [1:0]  resolution;
		logic [3:0]  chip_error;
		logic        term_on;
	} tvr_core_stat_t;

endpackage : tvr_pkg

// [verilog/tvr_register_bank.sv]
// Function
// R1: Has-data bit follows buffer content per mode.
// R2: Threshold reached sets almost-full, requests interrupt.
// R3: Fill threshold resets to 64 words.
// R4: Full flag at capacity minus 33 words.
// R5: Status reports mode, header enable, pair mode.
// R6: Two-bit resolution field with fixed encoding.
// R7: One error bit per converter chip.
// R8: Bus-error bit sticky, cleared by status read.
// R9: Trigger-dropped bit sticky, cleared by status read.
// R10: Purged when empty or sent; chain end clears.
// R11: Two writable relocation bytes, A31-24 and A23-16.
// R12: Relocation select picks base; old base ignored.
// R13: Three-bit interrupt level, zero disables requests.
// R14: Acknowledge cycle returns 8-bit vector, default DD.
// R15: Slot register defaults ones, exported for headers.
// R16: Any module reset access pulses module reset.
// R17: Software clear pulses clear, zeroes event counter.
// R18: Software trigger write makes one trigger.
// R19: Event counter counts triggers in window mode.
// R20: Events-stored register reads buffer event count.
// R21: Block event count 8-bit, default 0, D16.
// R22: Loopback writes load buffer, block chip data.
`timescale 1ns/1ps
module tvr_register_bank
	import tvr_pkg::*;
(
	// Clock and reset.
	input  wire logic           sys_clk,
	input  wire logic           rst_n,
	// Register bus.
	input  wire tvr_bus_req_t   bus_req,
	input  wire logic [15:0]    rotary_base,
	input  wire logic           iack_valid,
	input  wire logic [2:0]     iack_level,
	output logic                bus_ack,
	output logic                bus_berr,
	output logic [31:0]         bus_rdata,
	// Acquisition core.
	input  wire tvr_core_stat_t core,
	input  wire logic           ext_trigger,
	input  wire logic           trigger_dropped,
	input  wire logic           core_berr,
	input  wire logic           cblt_all_sent,
	input  wire logic           cblt_end_berr,
	input  wire logic           test_fifo_en,
	// Controls towards the core.
	output logic                irq_req,
	output logic [2:0]          irq_level,
	output logic                module_reset_pulse,
	output logic                soft_clear_pulse,
	output logic                event_reset_pulse,
	output logic                trigger_pulse,
	output logic                loop_valid,
	output logic [31:0]         loop_data,
	output logic                chip_data_block,
	output logic [4:0]          slot_position,
	output logic [7:0]          block_events,
	output logic [7:0]          mcst_base,
	output logic [7:0]          chain_ctrl,
	output logic                output_has_data,
	output logic                almost_full,
	output logic                buffer_full
);

	logic [7:0]  reloc_hi_reg;
	logic [7:0]  reloc_lo_reg;
	logic        reloc_sel_reg;
	logic [2:0]  irq_level_reg;
	logic [7:0]  vector_reg;
	logic [4:0]  slot_reg;
	logic [7:0]  mcst_reg;
	logic [7:0]  chain_reg;
	logic [15:0] fill_threshold_reg;
	logic [7:0]  blk_reg;
	logic [31:0] evcnt_reg;
	logic [31:0] loop_reg;
	logic        berr_seen_reg;
	logic        trg_lost_reg;
	logic        purged_reg;

	function automatic logic reg_hit(input logic [31:0] a,
		input logic [15:0] base, input logic [15:0] off);
		return (a[31:16] == base) && (a[15:0] == off);
	endfunction : reg_hit

	// Address decode.
	wire [15:0] base_sel = reloc_sel_reg ?
		{reloc_hi_reg, reloc_lo_reg} : rotary_base; // R12
	wire base_hit = bus_req.valid && (bus_req.addr[31:16] == base_sel);
	wire wr = base_hit && bus_req.write;
	wire rd = base_hit && !bus_req.write;
	wire s_status = reg_hit(bus_req.addr, base_sel, OFF_STATUS);
	wire s_rhi    = reg_hit(bus_req.addr, base_sel, OFF_RELOC_HI);
	wire s_rlo    = reg_hit(bus_req.addr, base_sel, OFF_RELOC_LO);
	wire s_rsel   = reg_hit(bus_req.addr, base_sel, OFF_RELOC_SEL);
	wire s_ilev   = reg_hit(bus_req.addr, base_sel, OFF_IRQ_LEVEL);
	wire s_ivec   = reg_hit(bus_req.addr, base_sel, OFF_IRQ_VEC);
	wire s_slot   = reg_hit(bus_req.addr, base_sel, OFF_SLOT);
	wire s_mcst   = reg_hit(bus_req.addr, base_sel, OFF_MCST);
	wire s_chain  = reg_hit(bus_req.addr, base_sel, OFF_CHAIN);
	wire s_mreset = reg_hit(bus_req.addr, base_sel, OFF_MRESET);
	wire s_sclear = reg_hit(bus_req.addr, base_sel, OFF_SCLEAR);
	wire s_evres  = reg_hit(bus_req.addr, base_sel, OFF_EVRESET);
	wire s_strig  = reg_hit(bus_req.addr, base_sel, OFF_STRIG);
	wire s_evcnt  = reg_hit(bus_req.addr, base_sel, OFF_EVCNT);
	wire s_evst   = reg_hit(bus_req.addr, base_sel, OFF_EVSTORED);
	wire s_fill   = reg_hit(bus_req.addr, base_sel, OFF_FILL);
	wire s_blk    = reg_hit(bus_req.addr, base_sel, OFF_BLKEV);
	wire s_fwrev  = reg_hit(bus_req.addr, base_sel, OFF_FWREV);
	wire s_loop   = reg_hit(bus_req.addr, base_sel, OFF_LOOP);
	wire known = s_status | s_rhi | s_rlo | s_rsel | s_ilev | s_ivec
		| s_slot | s_mcst | s_chain | s_mreset | s_sclear | s_evres
		| s_strig | s_evcnt | s_evst | s_fill | s_blk | s_fwrev | s_loop;
	// Wrong data width on the fixed-width locations ends in a bus error.
	wire width_bad = (s_blk && bus_req.wide) // R21
		|| ((s_loop || s_evcnt) && !bus_req.wide);
	wire berr_now = base_hit && (!known || width_bad);
	wire good = base_hit && !berr_now;
	wire iack_hit = iack_valid && irq_req
		&& (iack_level == irq_level_reg) && !base_hit;
	wire mreset_now = good && s_mreset; // R16
	wire sclear_now = good && wr && s_sclear;
	wire strig_now = good && wr && s_strig;
	wire status_rd = good && rd && s_status;
	wire loop_wr = good && wr && s_loop;

	// Live status.
	wire has_data_now = core.trig_window ?
		(core.events != 16'h0000) : (core.words != 16'h0000); // R1
	wire afull_now = core.words >= fill_threshold_reg; // R2
	wire full_now = core.words >= FULL_LEVEL; // R4
	wire [15:0] status_word;
	assign status_word[ST_HAS_DATA] = output_has_data;
	assign status_word[ST_AFULL] = almost_full;
	assign status_word[ST_FULL] = buffer_full;
	assign status_word[ST_TRIGWIN] = core.trig_window; // R5
	assign status_word[ST_HEADER] = core.header_en; // R5
	assign status_word[ST_TERM] = core.term_on;
	assign status_word[ST_ERR0 +: 4] = core.chip_error; // R7
	assign status_word[ST_BERR] = berr_seen_reg;
	assign status_word[ST_PURGED] = purged_reg;
	assign status_word[ST_RES0 +: 2] = core.resolution; // R6
	assign status_word[ST_PAIR] = core.pair_mode; // R5
	assign status_word[ST_TRGLOST] = trg_lost_reg;

	// Read data selection; write-only locations read as zero.
	wire [31:0] rd_mux =
		s_status ? {16'h0000, status_word} :
		s_rhi    ? {24'h00_0000, reloc_hi_reg} : // R11
		s_rlo    ? {24'h00_0000, reloc_lo_reg} : // R11
		s_ilev   ? {29'h0000_0000, irq_level_reg} :
		s_ivec   ? {24'h00_0000, vector_reg} :
		s_slot   ? {27'h000_0000, slot_reg} :
		s_mcst   ? {24'h00_0000, mcst_reg} :
		s_chain  ? {24'h00_0000, chain_reg} :
		s_evcnt  ? evcnt_reg :
		s_evst   ? {16'h0000, core.events} : // R20
		s_fill   ? {16'h0000, fill_threshold_reg} :
		s_blk    ? {24'h00_0000, blk_reg} :
		s_fwrev  ? {24'h00_0000, FW_REVISION} :
		s_loop   ? loop_reg : 32'h0000_0000;
	wire [31:0] rdata_next = iack_hit ?
		{24'h00_0000, vector_reg} : rd_mux; // R14

	// Bus answer, one cycle after the request.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_ack <= 1'b0;
			bus_berr <= 1'b0;
			bus_rdata <= 32'h0000_0000;
		end else begin
			bus_ack <= good || iack_hit;
			bus_berr <= berr_now;
			bus_rdata <= ((good && rd) || iack_hit) ? rdata_next
				: 32'h0000_0000;
		end
	end

	// Software-visible configuration; a module reset restores defaults.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n || 1'b0) begin
			reloc_hi_reg <= RST_RELOC;
			reloc_lo_reg <= RST_RELOC;
			reloc_sel_reg <= 1'b0;
			irq_level_reg <= RST_IRQ_LEVEL;
			vector_reg <= RST_IRQ_VEC;
			slot_reg <= RST_SLOT; // R15
			mcst_reg <= RST_MCST;
			chain_reg <= RST_CHAIN;
			fill_threshold_reg <= RST_FILL; // R3
			blk_reg <= RST_BLKEV; // R21
		end else if (mreset_now) begin
			reloc_hi_reg <= RST_RELOC;
			reloc_lo_reg <= RST_RELOC;
			reloc_sel_reg <= 1'b0;
			irq_level_reg <= RST_IRQ_LEVEL;
			vector_reg <= RST_IRQ_VEC;
			slot_reg <= RST_SLOT;
			mcst_reg <= RST_MCST;
			chain_reg <= RST_CHAIN;
			fill_threshold_reg <= RST_FILL;
			blk_reg <= RST_BLKEV;
		end else if (good && wr) begin
			if (s_rhi) reloc_hi_reg <= bus_req.wdata[7:0]; // R11
			if (s_rlo) reloc_lo_reg <= bus_req.wdata[7:0]; // R11
			if (s_rsel) reloc_sel_reg <= bus_req.wdata[0]; // R12
			if (s_ilev) irq_level_reg <= bus_req.wdata[2:0]; // R13
			if (s_ivec) vector_reg <= bus_req.wdata[7:0]; // R14
			if (s_slot) slot_reg <= bus_req.wdata[4:0]; // R15
			if (s_mcst) mcst_reg <= bus_req.wdata[7:0];
			if (s_chain) chain_reg <= bus_req.wdata[7:0];
			if (s_fill) fill_threshold_reg <= bus_req.wdata[15:0];
			if (s_blk) blk_reg <= bus_req.wdata[7:0]; // R21
		end
	end

	// Event counter and sticky status bits; a clear beats a count, and a
	// new sticky event beats the status read that would clear it.
	wire count_now = core.trig_window && (ext_trigger || strig_now);
	wire [31:0] evcnt_next = (sclear_now || mreset_now) ? 32'h0000_0000
		: count_now ? evcnt_reg + 32'h0000_0001 : evcnt_reg; // R17 R19
	wire berr_next = berr_now || core_berr
		|| (berr_seen_reg && !status_rd); // R8
	wire trg_lost_next = trigger_dropped
		|| (trg_lost_reg && !status_rd); // R9
	wire purged_next = (core.words == 16'h0000) || cblt_all_sent
		|| (purged_reg && !cblt_end_berr); // R10
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			evcnt_reg <= 32'h0000_0000;
			berr_seen_reg <= 1'b0;
			trg_lost_reg <= 1'b0;
			purged_reg <= 1'b1;
		end else begin
			evcnt_reg <= evcnt_next;
			berr_seen_reg <= berr_next;
			trg_lost_reg <= trg_lost_next;
			purged_reg <= purged_next;
		end
	end

	// Strobes, loopback and flags towards the core.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			module_reset_pulse <= 1'b0;
			soft_clear_pulse <= 1'b0;
			event_reset_pulse <= 1'b0;
			trigger_pulse <= 1'b0;
			loop_valid <= 1'b0;
			loop_reg <= 32'h0000_0000;
			chip_data_block <= 1'b0;
			irq_req <= 1'b0;
			output_has_data <= 1'b0;
			almost_full <= 1'b0;
			buffer_full <= 1'b0;
		end else begin
			module_reset_pulse <= mreset_now; // R16
			soft_clear_pulse <= sclear_now; // R17
			event_reset_pulse <= good && wr && s_evres;
			trigger_pulse <= strig_now; // R18
			loop_valid <= loop_wr && test_fifo_en; // R22
			if (loop_wr) loop_reg <= bus_req.wdata;
			chip_data_block <= test_fifo_en; // R22
			irq_req <= afull_now && (irq_level_reg != 3'h0); // R2 R13
			output_has_data <= has_data_now; // R1
			almost_full <= afull_now; // R2
			buffer_full <= full_now; // R4
		end
	end

	assign loop_data = loop_reg;
	assign irq_level = irq_level_reg;
	assign slot_position = slot_reg;
	assign block_events = blk_reg;
	assign mcst_base = mcst_reg;
	assign chain_ctrl = chain_reg;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	has_data_a: assert property ( // R1
		output_has_data == $past(has_data_now) || !$past(rst_n))
		else $error("has-data flag wrong");
	afull_irq_a: assert property ( // R2
		afull_now && irq_level_reg != 3'h0 |=> almost_full && irq_req)
		else $error("almost-full not raised");
	fill_reset_a: assert property ( // R3
		!$past(rst_n) |-> fill_threshold_reg == 16'h0040)
		else $error("fill threshold reset wrong");
	full_flag_a: assert property ( // R4
		##1 buffer_full == ($past(core.words) >= 16'd32735))
		else $error("full flag wrong");
	status_mode_a: assert property ( // R5
		status_rd |=> bus_rdata[ST_TRIGWIN] == $past(core.trig_window)
			&& bus_rdata[ST_PAIR] == $past(core.pair_mode))
		else $error("mode bits wrong");
	status_res_a: assert property ( // R6
		status_rd |=> bus_rdata[13:12] == $past(core.resolution))
		else $error("resolution field wrong");
	chip_error_a: assert property ( // R7
		status_rd |=> bus_rdata[9:6] == $past(core.chip_error))
		else $error("chip error bits wrong");
	berr_clear_a: assert property ( // R8
		status_rd && !core_berr |=> !berr_seen_reg)
		else $error("bus-error bit not cleared");
	berr_set_a: assert property ( // R8
		bus_berr |-> berr_seen_reg)
		else $error("bus-error bit not set");
	trg_lost_a: assert property ( // R9
		trigger_dropped |=> trg_lost_reg && status_word[ST_TRGLOST])
		else $error("trigger-dropped not set");
	trg_clear_a: assert property ( // R9
		status_rd && !trigger_dropped |=> !trg_lost_reg)
		else $error("trigger-dropped not cleared");
	evst_read_a: assert property ( // R20
		good && rd && s_evst |=> bus_rdata[15:0] == $past(core.events))
		else $error("events-stored read wrong");
	reloc_write_a: assert property ( // R11
		good && wr && s_rhi |=> reloc_hi_reg == $past(bus_req.wdata[7:0]))
		else $error("relocation byte not written");
	purged_set_a: assert property ( // R10
		core.words == 16'h0000 || cblt_all_sent |=> purged_reg)
		else $error("purged not set");
	purged_clear_a: assert property ( // R10
		cblt_end_berr && purged_reg && core.words != 16'h0000
			&& !cblt_all_sent |=> !purged_reg)
		else $error("purged not cleared");
	old_base_a: assert property ( // R12
		reloc_sel_reg && bus_req.valid
			&& bus_req.addr[31:16] != {reloc_hi_reg, reloc_lo_reg}
			&& !iack_hit |=> !bus_ack && !bus_berr)
		else $error("old base still answers");
	level_zero_a: assert property ( // R13
		irq_level_reg == 3'h0 |=> !irq_req)
		else $error("request with level zero");
	iack_vec_a: assert property ( // R14
		iack_hit |=> bus_ack && bus_rdata == {24'h0, $past(vector_reg)})
		else $error("vector not returned");
	mreset_defaults_a: assert property ( // R16
		mreset_now |=> module_reset_pulse && vector_reg == 8'hDD
			&& !reloc_sel_reg && evcnt_reg == 32'h0)
		else $error("module reset did not restore defaults");
	mreset_once_a: assert property ( // R16
		module_reset_pulse |-> $past(mreset_now))
		else $error("module reset pulse without access");
	clear_cnt_a: assert property ( // R17
		sclear_now |=> soft_clear_pulse && evcnt_reg == 32'h0)
		else $error("clear did not zero counter");
	sw_trig_a: assert property ( // R18
		strig_now && !sclear_now && core.trig_window
			|=> trigger_pulse && evcnt_reg == $past(evcnt_reg) + 1)
		else $error("software trigger lost");
	count_mode_a: assert property ( // R19
		!core.trig_window && !sclear_now && !mreset_now
			|=> $stable(evcnt_reg))
		else $error("counted outside window mode");
	blk_width_a: assert property ( // R21
		s_blk && bus_req.valid && bus_req.wide |=> bus_berr && !bus_ack)
		else $error("D32 access to block count accepted");
	chip_block_a: assert property ( // R22
		test_fifo_en |=> chip_data_block)
		else $error("chip data not blocked");
	loop_load_a: assert property ( // R22
		loop_wr && test_fifo_en |=> loop_valid
			&& loop_data == $past(bus_req.wdata) && chip_data_block)
		else $error("loopback word not loaded");

	reloc_move_c: cover property (good && wr && s_rsel
		&& bus_req.wdata[0] ##1 reloc_sel_reg);
	iack_c: cover property (iack_hit ##1 bus_ack);
	status_clear_c: cover property (berr_seen_reg && status_rd
		##1 !berr_seen_reg);
	loop_c: cover property (loop_wr && test_fifo_en ##1 loop_valid);

endmodule : tvr_register_bank

// [tb/tvr_bus_master.sv]
`timescale 1ns/1ps
module tvr_bus_master
	import tvr_pkg::*;
(
	// Clock and reset.
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// Register bus.
	output tvr_bus_req_t     bus_req,
	input  wire logic        bus_ack,
	input  wire logic        bus_berr,
	input  wire logic [31:0] bus_rdata
);
	initial bus_req = '0;
	// Response code: 0 none, 1 acknowledge, 2 bus error.
	task automatic xfer(input logic w, input logic wd,
		input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic [1:0] r);
		r = 2'h0;
		q = 32'h0000_0000;
		@(posedge sys_clk);
		bus_req <= '{1'b1, w, wd, a, d};
		@(posedge sys_clk);
		// Released lines are inverted so a stale value never matches.
		bus_req <= '{1'b0, ~w, ~wd, ~a, ~d};
		repeat (3) begin
			@(posedge sys_clk);
			if (r == 2'h0 && bus_ack === 1'b1) begin
				r = 2'h1;
				q = bus_rdata;
			end
			if (r == 2'h0 && bus_berr === 1'b1)
				r = 2'h2;
		end
	endtask : xfer
endmodule : tvr_bus_master

// [tb/tdc_vme_register_bank_tb.sv]
`timescale 1ns/1ps
module tdc_vme_register_bank_tb;
	import tvr_pkg::*;
	logic           sys_clk, rst_n, iack_valid, tfe, all_sent;
	tvr_bus_req_t   bus_req;
	tvr_core_stat_t core;
	logic [15:0]    rot, bs, nb, t, w;
	logic [2:0]     iack_level, irq_level;
	logic [3:0]     pls, pz;
	logic           bus_ack, bus_berr, irq_req, loop_valid;
	logic           module_reset_pulse, soft_clear_pulse;
	logic           event_reset_pulse, trigger_pulse, chip_data_block;
	logic           output_has_data, almost_full, buffer_full;
	logic [31:0]    bus_rdata, loop_data, rd_d, lw, lv, e;
	logic [4:0]     slot_position;
	logic [7:0]     block_events, mcst_base, chain_ctrl;
	logic [1:0]     rsp;
	int             errors, comparisons, cyc, c;
	int             cnt[5];
	logic [15:0]    cw[5];
	logic [15:0]    wv[9];
	logic [15:0]    so[4] = '{OFF_MRESET, OFF_SCLEAR, OFF_EVRESET, OFF_STRIG};
	logic [15:0]    ro[9] = '{OFF_RELOC_HI, OFF_RELOC_LO, OFF_IRQ_LEVEL,
		OFF_IRQ_VEC, OFF_SLOT, OFF_MCST, OFF_CHAIN, OFF_FILL, OFF_BLKEV};
	logic [15:0]    rm[9] = '{16'h00FF, 16'h00FF, 16'h0007, 16'h00FF,
		16'h001F, 16'h00FF, 16'h00FF, 16'hFFFF, 16'h00FF};
	logic [15:0]    rv[9] = '{16'h0000, 16'h0000, 16'h0000, 16'h00DD,
		16'h001F, 16'h00AA, 16'h0000, 16'h0040, 16'h0000};

	tvr_register_bank DUT (
		.sys_clk, .rst_n, .bus_req, .rotary_base(rot), .iack_valid,
		.iack_level, .bus_ack, .bus_berr, .bus_rdata, .core,
		.ext_trigger(pls[0]), .trigger_dropped(pls[1]),
		.core_berr(pls[2]), .cblt_all_sent(all_sent),
		.cblt_end_berr(pls[3]), .test_fifo_en(tfe), .irq_req,
		.irq_level, .module_reset_pulse, .soft_clear_pulse,
		.event_reset_pulse, .trigger_pulse, .loop_valid, .loop_data,
		.chip_data_block, .slot_position, .block_events, .mcst_base,
		.chain_ctrl, .output_has_data, .almost_full, .buffer_full
	);
	tvr_bus_master u_cpu (
		.sys_clk, .rst_n, .bus_req, .bus_ack, .bus_berr, .bus_rdata
	);

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	assign pz = {trigger_pulse, event_reset_pulse, soft_clear_pulse,
		module_reset_pulse};
	// Pulses are counted per cycle, so a stretched pulse counts twice.
	always @(posedge sys_clk) begin
		cyc++;
		for (int i = 0; i < 4; i++)
			if (pz[i] === 1'b1) cnt[i]++;
		if (loop_valid === 1'b1) begin
			cnt[4]++;
			lw = loop_data;
		end
		if (cyc == 20000) begin
			errors++;
			close_out();
		end
	end

	task automatic close_out();
		$display("comparisons=%0d errors=%0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out

	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		comparisons++;
		if (s !== x) begin
			errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask : chk

	task automatic acc(input logic wr, input logic [15:0] o,
		input logic [31:0] d);
		u_cpu.xfer(wr, o == OFF_EVCNT || o == OFF_LOOP, {bs, o}, d,
			rd_d, rsp);
	endtask : acc

	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : step

	task automatic pulse(input int b);
		@(posedge sys_clk);
		pls[b] <= 1'b1;
		@(posedge sys_clk);
		pls[b] <= 1'b0;
	endtask : pulse

	task automatic strb(input int i, input logic wr);
		int c0;
		c0 = cnt[i];
		acc(wr, so[i], 32'($urandom));
		step(1);
		chk(cnt[i], c0 + 1);
	endtask : strb

	function automatic logic [2:0] flags(input logic [15:0] n,
		input logic [15:0] ev, input logic tw, input logic [15:0] th);
		return {n >= 16'h7FDF, n >= th, tw ? ev != 0 : n != 0};
	endfunction : flags

	initial begin
		rst_n = 1'b0;
		core = '0;
		iack_valid = 1'b0;
		iack_level = 3'h0;
		pls = 4'h0;
		tfe = 1'b0;
		all_sent = 1'b0;
		errors = 0;
		comparisons = 0;
		cyc = 0;
		cnt = '{default: 0};
		void'($urandom(91));
		rot = 16'($urandom);
		bs = rot;
		step(20);
		rst_n <= 1'b1;
		for (int i = 0; i < 9; i++) begin
			acc(0, ro[i], '0);
			chk(rd_d & rm[i], rv[i]);
			wv[i] = 16'($urandom) & rm[i];
			if (ro[i] == OFF_FILL) wv[i] = 16'(1 + $urandom % 32735);
			acc(1, ro[i], wv[i]);
			acc(0, ro[i], '0);
			chk(rd_d & rm[i], wv[i]);
		end
		chk(slot_position, wv[4]);
		chk(block_events, wv[8]);
		chk({mcst_base, chain_ctrl, irq_level},
			{wv[5][7:0], wv[6][7:0], wv[2][2:0]});
		acc(1, OFF_STATUS, 32'h0000_FFFF);
		chk(rsp, 2'h1);
		acc(0, 16'h1040, '0);
		chk(rsp, 2'h2);
		u_cpu.xfer(0, 1, {bs, OFF_BLKEV}, '0, rd_d, rsp);
		chk(rsp, 2'h2);
		pulse(1);
		acc(0, OFF_STATUS, '0);
		chk({rd_d[15], rd_d[10]}, 2'h3);
		acc(0, OFF_STATUS, '0);
		chk({rd_d[15], rd_d[10]}, 2'h0);
		pulse(2);
		acc(0, OFF_STATUS, '0);
		chk(rd_d[10], 1'b1);
		$display("test registers done");
		t = wv[7];
		cw = '{t - 16'h0001, t, 16'h7FDE, 16'h7FDF, 16'h0000};
		for (int p = 0; p < 2; p++) begin
			acc(1, OFF_IRQ_LEVEL, p ? 32'h0000_0003 : 32'h0000_0000);
			for (int i = 0; i < 12; i++) begin
				w = (i < 5) ? cw[i] : 16'($urandom % 32768);
				@(posedge sys_clk);
				core.words <= w;
				core.events <= 16'($urandom % 3);
				core.trig_window <= 1'($urandom);
				step(3);
				e = flags(w, core.events, core.trig_window, t);
				chk({buffer_full, almost_full, output_has_data}, e);
				chk(irq_req, w >= t && p == 1);
			end
		end
		@(posedge sys_clk);
		core.words <= t;
		step(4);
		iack_valid <= 1'b1;
		iack_level <= 3'h3;
		@(posedge sys_clk);
		iack_valid <= 1'b0;
		@(posedge sys_clk);
		chk(bus_ack, 1'b1);
		chk(bus_rdata, wv[3]);
		$display("test flags done");
		for (int r = 0; r < 4; r++) begin
			@(posedge sys_clk);
			core.resolution <= 2'(r);
			core.header_en <= 1'($urandom);
			core.pair_mode <= 1'($urandom);
			core.chip_error <= 4'($urandom);
			core.term_on <= 1'($urandom);
			core.events <= 16'($urandom);
			step(2);
			acc(0, OFF_STATUS, '0);
			e = {core.pair_mode, core.resolution, core.chip_error,
				core.term_on, core.header_en, core.trig_window};
			chk({rd_d[14:12], rd_d[9:3]}, e);
			acc(0, OFF_EVSTORED, '0);
			chk(rd_d[15:0], core.events);
		end
		for (int i = 0; i < 4; i++) begin
			@(posedge sys_clk);
			core.words <= (i == 0) ? 16'h0000 : 16'h0005;
			all_sent <= (i == 1);
			if (i == 3) pulse(3);
			step(2);
			acc(0, OFF_STATUS, '0);
			chk(rd_d[11], i != 3);
		end
		$display("test status done");
		strb(1, 1);
		@(posedge sys_clk);
		core.trig_window <= 1'b1;
		repeat (3) pulse(0);
		strb(3, 1);
		acc(0, OFF_EVCNT, '0);
		chk(rd_d, 32'h0000_0004);
		strb(2, 1);
		strb(1, 1);
		acc(0, OFF_EVCNT, '0);
		chk(rd_d, 32'h0000_0000);
		@(posedge sys_clk);
		core.trig_window <= 1'b0;
		repeat (2) pulse(0);
		acc(0, OFF_EVCNT, '0);
		chk(rd_d, 32'h0000_0000);
		$display("test strobes done");
		nb = ~rot;
		acc(1, OFF_RELOC_HI, 32'(nb[15:8]));
		acc(1, OFF_RELOC_LO, 32'(nb[7:0]));
		acc(1, OFF_RELOC_SEL, 32'h0000_0001);
		acc(0, OFF_IRQ_VEC, '0);
		chk(rsp, 2'h0);
		bs = nb;
		acc(0, OFF_IRQ_VEC, '0);
		chk(rd_d[7:0], wv[3][7:0]);
		strb(0, 0);
		acc(0, OFF_IRQ_VEC, '0);
		chk(rsp, 2'h0);
		bs = rot;
		acc(0, OFF_IRQ_VEC, '0);
		chk(rd_d[7:0], 8'hDD);
		$display("test relocation done");
		@(posedge sys_clk);
		tfe <= 1'b1;
		lv = $urandom;
		c = cnt[4];
		acc(1, OFF_LOOP, lv);
		step(1);
		chk(cnt[4], c + 1);
		chk(lw, lv);
		chk(chip_data_block, 1'b1);
		@(posedge sys_clk);
		tfe <= 1'b0;
		acc(1, OFF_LOOP, ~lv);
		step(1);
		chk(cnt[4], c + 1);
		chk(chip_data_block, 1'b0);
		acc(0, OFF_LOOP, '0);
		chk(rd_d, ~lv);
		$display("test loopback done");
		close_out();
	end
endmodule : tdc_vme_register_bank_tb
